// File: isr_pkg.sv
// constants and types for the image sensor readout block
package isr_pkg;
  // =====================================================
  // register map (serial address, 7 bits)
  localparam logic [6:0] ADDR_PIXEL  = 7'h08;
  localparam logic [6:0] ADDR_EXP_HI = 7'h0E;
  localparam logic [6:0] ADDR_EXP_LO = 7'h0F;
  localparam logic [6:0] ADDR_PROD   = 7'h11;
  // =====================================================
  // pixel array and dump byte layout
  localparam int         PIX_PER_COL = 18;
  localparam int         NUM_COLS    = 18;
  localparam int         NUM_PIX     = PIX_PER_COL * NUM_COLS;
  localparam logic [8:0] LAST_PIX    = 9'(NUM_PIX - 1);
  localparam logic [5:0] PIX_BLACK   = 6'h00;
  localparam logic [5:0] PIX_WHITE   = 6'h3F;
  localparam int         SOF_BIT     = 7;
  localparam int         VALID_BIT   = 6;
  // =====================================================
  // exposure and gain loop
  localparam logic [15:0] EXP_RESET  = 16'h0100;
  localparam logic [15:0] EXP_MIN    = 16'h0010;
  localparam int          EXP_SHIFT  = 4;
  localparam int          EXP_OFFS   = 3476;
  localparam int          CLK_REF_HZ = 24000000;
  localparam int          FRAME_RATE = 1512;
  localparam logic [5:0]  AGC_LOW    = 6'h35;
  localparam logic [5:0]  AGC_HIGH   = 6'h39;
  // =====================================================
  // identification register
  localparam logic [3:0]  ID_RSVD    = 4'hF;
  // =====================================================
  // serial engine states
  typedef enum logic [1:0] {
    SER_ADDR  = 2'b00,
    SER_WDATA = 2'b01,
    SER_RDATA = 2'b11
  } isr_ser_type;
endpackage : isr_pkg

// File: isr_readout.sv
// pixel dump, exposure loop and id registers behind the two-wire port
//
// How it works
// - pixels numbered column-major, 18 per column
// - pixel value is 6 bits, 0 black
// - gain loop keeps frame maximum mid fifties
// - exposure is 16 bits, two byte registers
// - exposure starts at 0x0100 after reset
// - each change is one sixteenth of value, or a clamp to the cap or the 0x0010 floor
// - exposure capped at clock over rate minus 3476
// - default cap is 12397 cycles
// - id register holds inverted 4-bit code
// - pixel write resets pointer to pixel zero
// - dump byte: frame start, valid, value
`timescale 1ns/10ps
`default_nettype none

module isr_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 16
) (
  // clock, reset, enable
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic             ce,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire              do_wr = ce && in_valid && in_ready;
  wire              do_rd = ce && out_valid && out_ready;

  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge sys_clk)
  begin
    if (do_wr)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : isr_fifo

module isr_readout
  import isr_pkg::*;
#(
  parameter int         SENSOR_CLK_HZ = CLK_REF_HZ,
  parameter int         FRAMES_PER_S  = FRAME_RATE,
  parameter logic [3:0] PRODUCT_CODE  = 4'h5  // arbitrary value
) (
  // clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // two-wire serial port
  input  wire logic        sck,
  input  wire logic        sdio_in,
  output logic             sdio_out,
  output logic             sdio_oe,
  // pixel stream from the array, pixel number order
  input  wire logic        pix_valid,
  output logic             pix_ready,
  input  wire logic        pix_first,
  input  wire logic [5:0]  pix_value,
  // exposure to the array
  output logic      [15:0] exposure
);
  localparam logic [15:0] EXP_MAX =
    16'(SENSOR_CLK_HZ / FRAMES_PER_S - EXP_OFFS);

  // =====================================================
  // pin synchronisers
  logic [1:0] sck_sync;
  logic [1:0] sdi_sync;
  logic       sck_prev;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sck_sync <= 2'b00;
      sdi_sync <= 2'b00;
      sck_prev <= 1'b0;
    end
    else if (ce)
    begin
      sck_sync <= {sck_sync[0], sck};
      sdi_sync <= {sdi_sync[0], sdio_in};
      sck_prev <= sck_sync[1];
    end
  end
  wire sck_rise = sck_sync[1] && !sck_prev;
  wire sck_fall = !sck_sync[1] && sck_prev;

  // =====================================================
  // serial engine
  isr_ser_type ser_state;
  logic [2:0]  bit_cnt;
  logic [7:0]  rx_shift;
  logic [7:0]  tx_shift;
  logic [6:0]  addr;
  wire  [7:0]  rx_byte  = {rx_shift[6:0], sdi_sync[1]};
  wire         byte_end = sck_rise && bit_cnt == 3'h7;
  wire         addr_end = byte_end && ser_state == SER_ADDR;
  wire         load_rd  = addr_end && !rx_byte[7];
  wire         wr_done  = byte_end && ser_state == SER_WDATA;
  wire         wr_pix   = wr_done && addr == ADDR_PIXEL;
  wire         rd_pix   = load_rd && rx_byte[6:0] == ADDR_PIXEL;
  wire         rd_hi    = load_rd && rx_byte[6:0] == ADDR_EXP_HI;
  wire         rd_busy  = ser_state == SER_RDATA;

  assign sdio_out = tx_shift[7];
  assign sdio_oe  = rd_busy;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ser_state <= SER_ADDR;
      bit_cnt   <= 3'h0;
      rx_shift  <= 8'h00;
      addr      <= 7'h00;
    end
    else if (ce && sck_rise)
    begin
      rx_shift <= rx_byte;
      bit_cnt  <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7)
      begin
        case (ser_state)
          SER_ADDR:
          begin
            addr      <= rx_byte[6:0];
            ser_state <= rx_byte[7] ? SER_WDATA : SER_RDATA;
          end
          default: ser_state <= SER_ADDR;
        endcase
      end
    end
  end

  // =====================================================
  // read data selection
  logic [7:0] exp_lo_latch;
  logic [8:0] ptr;
  logic       grab_valid;
  logic [5:0] grab_value;
  wire  [7:0] pix_byte = {ptr == 9'h000, grab_valid, grab_value};
  wire  [7:0] id_byte  = {ID_RSVD, ~PRODUCT_CODE};
  wire  [7:0] rd_byte  = reg_read(rx_byte[6:0], pix_byte, id_byte);

  function automatic logic [7:0] reg_read(
    input logic [6:0] a,
    input logic [7:0] pix,
    input logic [7:0] id
  );
    logic [7:0] r;
    r = 8'h00;
    case (a)
      ADDR_PIXEL:  r = pix;
      ADDR_EXP_HI: r = exposure[15:8];
      ADDR_EXP_LO: r = exp_lo_latch;
      ADDR_PROD:   r = id;
      default:     r = 8'h00;
    endcase
    return r;
  endfunction : reg_read

  // first bit is already out when the host samples, so no shift before
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      tx_shift <= 8'h00;
    else if (ce)
    begin
      if (load_rd)
        tx_shift <= rd_byte;
      else if (sck_fall && rd_busy && bit_cnt != 3'h0)
        tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end

  // low byte frozen at high read
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      exp_lo_latch <= EXP_RESET[7:0];
    else if (ce && rd_hi)
      exp_lo_latch <= exposure[7:0];
  end

  // =====================================================
  // pixel stream buffer
  logic       fb_valid;
  logic [6:0] fb_data;
  // any register read in flight holds the stream so the grabber stays put
  wire        fb_ready = !rd_busy;
  wire        fb_take  = ce && fb_valid && fb_ready;
  wire        fb_first = fb_data[6];
  wire  [5:0] fb_value = fb_data[5:0];

  isr_fifo #(
    .WIDTH (7),
    .DEPTH (16)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .ce        (ce),
    .in_valid  (pix_valid),
    .in_ready  (pix_ready),
    .in_data   ({pix_first, pix_value}),
    .out_valid (fb_valid),
    .out_ready (fb_ready),
    .out_data  (fb_data)
  );

  // =====================================================
  // frame position and pixel grabber
  logic [8:0] idx;
  logic [5:0] frame_max;
  logic       armed;
  wire  [8:0] cur_idx   = fb_first ? 9'h000 : idx;
  wire  [5:0] cur_max   = (fb_first || fb_value > frame_max) ? fb_value : frame_max;
  wire        frame_end = fb_take && cur_idx == LAST_PIX;
  wire        grab      = fb_take && armed && !grab_valid && cur_idx == ptr;

  // index counts up each column, then next column
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      idx       <= 9'h000;
      frame_max <= PIX_BLACK;
    end
    else if (fb_take)
    begin
      idx       <= (cur_idx == LAST_PIX) ? 9'h000 : cur_idx + 9'h001;
      frame_max <= cur_max;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ptr        <= 9'h000;
      grab_valid <= 1'b0;
      grab_value <= PIX_BLACK;
      armed      <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_pix)
      begin
        ptr        <= 9'h000;
        grab_valid <= 1'b0;
        armed      <= 1'b1;
      end
      else if (rd_pix)
      begin
        armed <= 1'b1;
        if (grab_valid)
        begin
          grab_valid <= 1'b0;
          ptr        <= (ptr == LAST_PIX) ? 9'h000 : ptr + 9'h001;
        end
        else if (grab)
        begin
          // capture wins over an empty read in the same cycle
          grab_value <= fb_value;
          grab_valid <= 1'b1;
        end
      end
      else if (grab)
      begin
        grab_value <= fb_value;
        grab_valid <= 1'b1;
      end
    end
  end

  // =====================================================
  // automatic gain loop, one step per frame
  logic        seen_frame;
  wire  [15:0] exp_step = exposure >> EXP_SHIFT;
  wire  [16:0] exp_up   = {1'b0, exposure} + {1'b0, exp_step};
  wire  [15:0] exp_dn   = exposure - exp_step;
  wire  [15:0] next_up  = (exp_up > {1'b0, EXP_MAX}) ? EXP_MAX : exp_up[15:0];
  wire  [15:0] next_dn  = (exp_dn < EXP_MIN) ? EXP_MIN : exp_dn;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      exposure   <= EXP_RESET;
      seen_frame <= 1'b0;
    end
    else if (frame_end)
    begin
      seen_frame <= 1'b1;
      if (cur_max > AGC_HIGH)
        exposure <= next_dn;
      else if (cur_max < AGC_LOW)
        exposure <= next_up;
    end
  end

  // =====================================================
  // checks
  // cap never exceeded
  AST_EXP_CAP: assert property (@(posedge sys_clk) disable iff (!nrst)
    exposure <= EXP_MAX) else $error("exposure above cap");
  AST_CAP_DEFAULT: assert property (@(posedge sys_clk) disable iff (!nrst)
    (SENSOR_CLK_HZ != CLK_REF_HZ || FRAMES_PER_S != FRAME_RATE
     || EXP_MAX == 16'h306D)) else $error("default cap wrong");
  // start value holds until first frame
  AST_EXP_START: assert property (@(posedge sys_clk) disable iff (!nrst)
    !seen_frame |-> exposure == EXP_RESET) else $error("exposure start wrong");
  // change is one sixteenth or clamp
  AST_EXP_STEP: assert property (@(posedge sys_clk) disable iff (!nrst)
    $changed(exposure) |-> (exposure == $past(exposure) + ($past(exposure) >> 4))
      || (exposure == $past(exposure) - ($past(exposure) >> 4))
      || exposure == EXP_MAX || exposure == EXP_MIN) else $error("bad exposure step");
  AST_AGC_DOWN: assert property (@(posedge sys_clk) disable iff (!nrst)
    frame_end && cur_max > AGC_HIGH && exposure > EXP_MIN
    |=> exposure < $past(exposure)) else $error("agc did not lower");
  AST_WR_REWIND: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_pix |=> ptr == 9'h000 && !grab_valid ##1 pix_byte[SOF_BIT])
    else $error("pixel pointer not rewound");
  AST_DUMP_BYTE: assert property (@(posedge sys_clk) disable iff (!nrst)
    rd_pix |=> tx_shift == {$past(ptr) == 9'h000, $past(grab_valid), $past(grab_value)})
    else $error("dump byte wrong");
  AST_PTR_RANGE: assert property (@(posedge sys_clk) disable iff (!nrst)
    ptr <= LAST_PIX && idx <= LAST_PIX) else $error("pixel index out of range");
  // latched low byte matches high read
  AST_LO_LATCH: assert property (@(posedge sys_clk) disable iff (!nrst)
    rd_hi |=> exp_lo_latch == $past(exposure[7:0])) else $error("low byte not latched");
  AST_ID_BYTE: assert property (@(posedge sys_clk) disable iff (!nrst)
    load_rd && rx_byte[6:0] == ADDR_PROD |=> tx_shift == {4'hF, ~PRODUCT_CODE})
    else $error("id byte wrong");

  COV_PIX_GRAB:   cover property (@(posedge sys_clk) disable iff (!nrst) grab ##[1:400] rd_pix);
  COV_EXP_UP:     cover property (@(posedge sys_clk) disable iff (!nrst)
    frame_end && cur_max < AGC_LOW);
  COV_PTR_WRAP:   cover property (@(posedge sys_clk) disable iff (!nrst)
    rd_pix && grab_valid && ptr == LAST_PIX);
  COV_FIFO_FULL:  cover property (@(posedge sys_clk) disable iff (!nrst) !pix_ready);
endmodule : isr_readout

`default_nettype wire

// File: isr_host_model.sv
// host controller model for the two-wire serial port
`timescale 1ns/10ps
`default_nettype none

module isr_host_model
  import isr_pkg::*;
(
  // clock
  input  wire logic sys_clk,
  // serial port, host side
  output logic      sck,
  output logic      sdio_drv,
  output logic      sdio_en,
  input  wire logic sdio_wire
);
  initial
  begin
    sck      = 1'b0;
    sdio_drv = 1'b0;
    sdio_en  = 1'b0;
  end

  // =====================================================
  // one access: address byte then data byte, sck idles low
  task automatic xfer(input logic [7:0] hdr, input logic [7:0] wdat, output logic [7:0] rdat);
    rdat = 8'h00;
    for (int i = 15; i >= 0; i--)
    begin
      if (i == 7 && !hdr[7])
      begin
        // let go first, then give the device time to take the line
        sdio_en <= 1'b0;
        repeat (4) @(posedge sys_clk);
      end
      sck <= 1'b0;
      if (i > 7 || hdr[7])
      begin
        sdio_en  <= 1'b1;
        sdio_drv <= (i > 7) ? hdr[i-8] : wdat[i];
      end
      repeat (4) @(posedge sys_clk);
      sck <= 1'b1;
      if (i < 8)
        rdat[i] = sdio_wire;
      repeat (4) @(posedge sys_clk);
    end
    sck     <= 1'b0;
    sdio_en <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask : xfer

  // high byte, then low byte at once
  task automatic read_exposure(output logic [15:0] val);
    xfer({1'b0, ADDR_EXP_HI}, 8'h00, val[15:8]);
    xfer({1'b0, ADDR_EXP_LO}, 8'h00, val[7:0]);
  endtask : read_exposure
endmodule : isr_host_model

`default_nettype wire

// File: isr_readout_test.sv
// self-checking bench for the image sensor readout block
`timescale 1ns/10ps
`default_nettype none

module isr_readout_test;
  import isr_pkg::*;
  localparam logic [3:0]  PCODE = 4'h5;  // arbitrary value
  localparam int          CAP   = CLK_REF_HZ / FRAME_RATE - EXP_OFFS;

  logic        sys_clk, nrst, ce, sck, sdio_in, sdio_out, sdio_oe, host_drv, host_en;
  logic        pix_valid, pix_ready, pix_first;
  logic        float_bit = 1'b0;
  logic [5:0]  pix_value;
  logic [15:0] exposure, exp_model, e16;
  logic [7:0]  rd;
  int          n_mismatch, tests_run;

  // a released line keeps changing rather than holding the last bit
  assign sdio_in = sdio_oe ? sdio_out : (host_en ? host_drv : float_bit);

  isr_readout #(.PRODUCT_CODE(PCODE)) u_isr_readout (
    .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .sck(sck), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .pix_first(pix_first), .pix_value(pix_value), .exposure(exposure));
  isr_host_model u_isr_host_model (
    .sys_clk(sys_clk), .sck(sck), .sdio_drv(host_drv), .sdio_en(host_en),
    .sdio_wire(sdio_in));

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) float_bit <= ~float_bit;

  // =====================================================
  // checking helpers
  task automatic check(input logic [15:0] got, input logic [15:0] want, input string what);
    tests_run++;
    if (got !== want)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s is %h, expected %h", $time, what, got, want);
    end
  endtask : check

  task automatic rd_reg(input logic [6:0] a, input logic [7:0] mask, input logic [7:0] want);
    u_isr_host_model.xfer({1'b0, a}, 8'h00, rd);
    check(16'(rd & mask), 16'(want), "register byte");
  endtask : rd_reg

  function automatic logic [5:0] pv(int k, int lim);
    int v;
    v = (k * 7 + 3) % 64;
    return 6'((v > lim) ? lim : v);
  endfunction : pv

  // =====================================================
  // one frame in pixel number order, brightest value lim
  task automatic frame(input int lim);
    int e;
    for (int k = 0; k < NUM_PIX; k++)
    begin
      pix_valid <= 1'b1;
      pix_first <= (k == 0);
      pix_value <= pv(k, lim);
      @(posedge sys_clk);
      while (!pix_ready) @(posedge sys_clk);
    end
    pix_valid <= 1'b0;
    repeat (30) @(posedge sys_clk);
    e = exp_model;
    if (lim > 57)
      e = (e - e / 16 < 16) ? 16 : e - e / 16;
    else if (lim < 53)
      e = (e + e / 16 > CAP) ? CAP : e + e / 16;
    exp_model = 16'(e);
    check(exposure, exp_model, "exposure port");
  endtask : frame

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (90000) @(posedge sys_clk);
    n_mismatch++;
    $display("unexpected at %0t: run did not finish", $time);
    tally_and_finish();
  end

  // =====================================================
  // test sequence
  initial
  begin
    nrst       = 1'b0;
    ce         = 1'b1;
    pix_valid  = 1'b0;
    pix_first  = 1'b0;
    pix_value  = 6'h00;
    n_mismatch = 0;
    tests_run  = 0;
    exp_model  = 16'h0100;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check(exposure, 16'h0100, "exposure after reset");
    u_isr_host_model.read_exposure(e16);
    check(e16, 16'h0100, "exposure bytes");
    $display("test reset exposure done");
    rd_reg(ADDR_PROD, 8'hFF, {4'hF, ~PCODE});
    u_isr_host_model.xfer({1'b1, ADDR_PROD}, 8'h00, rd);
    rd_reg(ADDR_PROD, 8'hFF, {4'hF, ~PCODE});
    rd_reg(7'h20, 8'hFF, 8'h00);
    $display("test id register done");
    u_isr_host_model.xfer({1'b1, ADDR_PIXEL}, 8'h5A, rd);
    rd_reg(ADDR_PIXEL, 8'hC0, 8'h80);
    // one valid read per frame toward an image
    for (int p = 0; p < 4; p++)
    begin
      frame(55);
      rd_reg(ADDR_PIXEL, 8'hFF, {p == 0, 1'b1, pv(p, 55)});
    end
    rd_reg(ADDR_PIXEL, 8'hC0, 8'h00);
    $display("test pixel dump done");
    repeat (70) frame(40);
    check(exposure, 16'h306D, "exposure at cap");
    rd_reg(ADDR_EXP_HI, 8'hFF, 8'h30);
    rd_reg(ADDR_EXP_LO, 8'hFF, 8'h6D);
    rd_reg(ADDR_EXP_HI, 8'hFF, 8'h30);
    frame(63);
    rd_reg(ADDR_EXP_LO, 8'hFF, 8'h6D);
    u_isr_host_model.read_exposure(e16);
    check(e16, exp_model, "exposure bytes");
    $display("test gain up and latch done");
    // slow single-count steps near the floor need the extra frames
    repeat (130) frame(63);
    check(exposure, 16'h0010, "exposure floor");
    $display("test gain down done");
    tally_and_finish();
  end
endmodule : isr_readout_test

`default_nettype wire
